/* rtl/bpc_pkg.sv */
/*
 * Shared constants and carrier types of the bidirectional port with
 * change interrupt: register byte offsets, field positions, reset values.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package bpc_pkg;

    localparam int          BPC_WIDTH       = 8;
    localparam int          BPC_ADDR_W      = 8;

    // register byte offsets
    localparam logic [7:0]  BPC_OFF_PIN     = 8'h00;
    localparam logic [7:0]  BPC_OFF_DIR     = 8'h04;
    localparam logic [7:0]  BPC_OFF_OPTION  = 8'h08;
    localparam logic [7:0]  BPC_OFF_STATUS  = 8'h0C;
    localparam logic [7:0]  BPC_OFF_MASK    = 8'h10;
    localparam logic [7:0]  BPC_OFF_BITSET  = 8'h14;
    localparam logic [7:0]  BPC_OFF_BITCLR  = 8'h18;

    // field positions
    localparam int          BPC_PULLUP_N_BIT = 7;
    localparam int          BPC_CHG_FLAG_BIT = 0;
    localparam int          BPC_CHG_LO       = 4;
    localparam int          BPC_CHG_HI       = 7;
    localparam int          BPC_LVP_PIN      = 4;

    // reset values
    localparam logic [7:0]  BPC_RST_LATCH   = 8'h00;
    localparam logic [7:0]  BPC_RST_DIR     = 8'hFF;
    localparam logic [7:0]  BPC_RST_OPTION  = 8'hFF;
    localparam logic [7:0]  BPC_RST_MASK    = 8'h00;

    localparam logic [1:0]  BPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  BPC_RESP_SLVERR = 2'h2;

    // alternate-function overrides, one bit per pin
    typedef struct packed {
        logic [7:0] take;      // function owns direction and data of the pin
        logic [7:0] drive;     // function drives the pin (else high impedance)
        logic [7:0] value;     // level the function drives
    } bpc_alt_s;

    // pin levels handed to the alternate-function peripherals
    typedef struct packed {
        logic ext_int;
        logic sync_serial_data;
        logic sync_serial_clk;
        logic capcomp_io;
        logic lv_prog_select;
        logic timer1_osc_out;
        logic timer1_clk_in;
        logic serial_prog_clk;
        logic timer1_osc_in;
        logic serial_prog_data;
    } bpc_tap_s;

endpackage : bpc_pkg

/* rtl/bpc_port.sv */
/*
 * Eight-bit bidirectional port with weak pull-ups, alternate-function
 * overrides and change interrupt on the upper four pins, behind an
 * AXI4-Lite slave. Assumes pin inputs synchronous to aclk, pads that
 * turn pin_out/pin_oe/pullup_en into the wire level, and a core that
 * raises sleep_active while asleep.
 */
`timescale 1ns/1ns
// What this block does
// - Eight pins each input or output, one byte port with byte direction register.
// - Direction bit one puts the pin driver in high impedance.
// - Direction bit zero drives the pin from its output latch.
// - An enabled alternate function may take over the pin direction.
// - Port read returns pin levels; port write updates the latch only.
// - Every port write samples pins, modifies that value, stores whole latch.
// - One active-low option bit seven enables all weak pull-ups together.
// - Pull-up turns off on any pin configured as output.
// - Pull-ups stay disabled after power-on reset until software enables them.
// - Only upper four input pins join change detection; outputs excluded.
// - Upper inputs compared to last-read value; ORed mismatch sets flag bit zero.
// - A pending change interrupt wakes the device from sleep.
// - Port read or write refreshes compare value; software then clears flag.
// - Persisting mismatch keeps setting the flag, so clearing alone fails.
// - A change coinciding with a port read may be absorbed without a flag.
// - Low-voltage programming disables change detection and pull-up on its pin.
// - Pins shared with interrupt, serial, capture/compare and timer1 functions.
module bpc_port
    import bpc_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // write address channel
    input  wire logic [BPC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // write data channel
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // write response channel
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // read address channel
    input  wire logic [BPC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // read data channel
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // pins
    input  wire logic [7:0]            pin_in,
    output logic [7:0]                 pin_out,
    output logic [7:0]                 pin_oe,
    output logic [7:0]                 pullup_en,
    // alternate functions
    input  wire bpc_alt_s              alt,
    output bpc_tap_s                   tap,
    // system
    input  wire logic                  lv_prog_enable,
    input  wire logic                  sleep_active,
    output logic                       wake_req,
    output logic                       irq
);

    function automatic logic hit(input logic [BPC_ADDR_W-1:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction : hit

    function automatic logic mapped(input logic [BPC_ADDR_W-1:0] addr);
        mapped = hit(addr, BPC_OFF_PIN) || hit(addr, BPC_OFF_DIR) || hit(addr, BPC_OFF_OPTION) ||
                 hit(addr, BPC_OFF_STATUS) || hit(addr, BPC_OFF_MASK) ||
                 hit(addr, BPC_OFF_BITSET) || hit(addr, BPC_OFF_BITCLR);
    endfunction : mapped

    logic [7:0]  sync1_r;
    logic [7:0]  sync2_r;
    logic [7:0]  latch_r;
    logic [7:0]  latch_nxt;
    logic [7:0]  dir_r;
    logic [7:0]  option_r;
    logic [3:0]  last_read_r;
    logic        chg_flag_r;
    logic        chg_mask_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic [7:0]  pin_out_r;
    logic [7:0]  pin_oe_r;
    logic [7:0]  pullup_r;
    logic        irq_r;
    logic        wake_r;
    bpc_tap_s    tap_r;

    logic        wr_go;
    logic        rd_go;
    logic        wr_lane0;
    logic        port_wr;
    logic        port_rd;
    logic        port_access;
    logic [7:0]  eff_input;
    logic [3:0]  chg_enable;
    logic        mismatch;
    logic        flag_clear;

    // write takes address and data together, one write in flight
    assign wr_go    = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
    assign rd_go    = s_axi_arvalid && !arready_r && !rvalid_r;
    assign wr_lane0 = s_axi_wstrb[0];

    // any write to the port data, bit-set or bit-clear address touches the latch
    assign port_wr     = wr_go && (hit(s_axi_awaddr, BPC_OFF_PIN) || hit(s_axi_awaddr, BPC_OFF_BITSET) ||
                                   hit(s_axi_awaddr, BPC_OFF_BITCLR));
    assign port_rd     = rd_go && hit(s_axi_araddr, BPC_OFF_PIN);
    assign port_access = port_wr || port_rd;

    // pin levels pass two flops before anything looks at them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // read-modify-write: the sampled pin value is the base of every latch write
    always_comb begin
        latch_nxt = latch_r;
        if (port_wr) begin
            latch_nxt = sync2_r;
            if (wr_lane0) begin
                if (hit(s_axi_awaddr, BPC_OFF_PIN)) begin
                    latch_nxt = s_axi_wdata[7:0];
                end else if (hit(s_axi_awaddr, BPC_OFF_BITSET)) begin
                    latch_nxt = sync2_r | s_axi_wdata[7:0];
                end else begin
                    latch_nxt = sync2_r & ~s_axi_wdata[7:0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_r <= BPC_RST_LATCH;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // direction, option and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_r      <= BPC_RST_DIR;
            option_r   <= BPC_RST_OPTION;
            chg_mask_r <= 1'b0;
        end else if (wr_go && wr_lane0) begin
            if (hit(s_axi_awaddr, BPC_OFF_DIR)) begin
                dir_r <= s_axi_wdata[7:0];
            end else if (hit(s_axi_awaddr, BPC_OFF_OPTION)) begin
                option_r <= s_axi_wdata[7:0];
            end else if (hit(s_axi_awaddr, BPC_OFF_MASK)) begin
                chg_mask_r <= s_axi_wdata[BPC_CHG_FLAG_BIT];
            end
        end
    end

    // a pin is an input when its owner (alternate function or direction bit) says so
    always_comb begin
        for (int i = 0; i < BPC_WIDTH; i++) begin
            eff_input[i] = alt.take[i] ? !alt.drive[i] : dir_r[i];
        end
    end

    // pin drivers and pull-ups
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_r <= 8'h00;
            pin_oe_r  <= 8'h00;
            pullup_r  <= 8'h00;
        end else begin
            for (int i = 0; i < BPC_WIDTH; i++) begin
                pin_out_r[i] <= alt.take[i] ? alt.value[i] : latch_nxt[i];
                pin_oe_r[i]  <= !eff_input[i];
                pullup_r[i]  <= !option_r[BPC_PULLUP_N_BIT] && eff_input[i];
            end
            if (lv_prog_enable) begin
                pullup_r[BPC_LVP_PIN] <= 1'b0;
            end
        end
    end

    // change detection on the upper inputs
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chg_enable[i] = eff_input[BPC_CHG_LO + i];
        end
        if (lv_prog_enable) begin
            chg_enable[BPC_LVP_PIN - BPC_CHG_LO] = 1'b0;
        end
    end

    assign mismatch   = |((sync2_r[BPC_CHG_HI:BPC_CHG_LO] ^ last_read_r) & chg_enable);
    assign flag_clear = wr_go && wr_lane0 && hit(s_axi_awaddr, BPC_OFF_STATUS) &&
                        s_axi_wdata[BPC_CHG_FLAG_BIT];

    // compare value refreshes on every port access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_read_r <= 4'h0;
        end else if (port_access) begin
            last_read_r <= sync2_r[BPC_CHG_HI:BPC_CHG_LO];
        end
    end

    // sticky flag: a set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chg_flag_r <= 1'b0;
        end else if (mismatch && !port_access) begin
            chg_flag_r <= 1'b1;
        end else if (flag_clear) begin
            chg_flag_r <= 1'b0;
        end
    end

    // interrupt and wake-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            irq_r  <= chg_flag_r && chg_mask_r;
            wake_r <= sleep_active && chg_flag_r && chg_mask_r;
        end
    end

    // synchronised pin levels handed to the alternate functions
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_r <= '0;
        end else begin
            tap_r.ext_int          <= sync2_r[0];
            tap_r.sync_serial_data <= sync2_r[1];
            tap_r.sync_serial_clk  <= sync2_r[2];
            tap_r.capcomp_io       <= sync2_r[3];
            tap_r.lv_prog_select   <= sync2_r[4];
            tap_r.timer1_osc_out   <= sync2_r[6];
            tap_r.timer1_clk_in    <= sync2_r[6];
            tap_r.serial_prog_clk  <= sync2_r[6];
            tap_r.timer1_osc_in    <= sync2_r[7];
            tap_r.serial_prog_data <= sync2_r[7];
        end
    end

    // write channels and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= BPC_RESP_OKAY;
        end else begin
            awready_r <= wr_go;
            wready_r  <= wr_go;
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= mapped(s_axi_awaddr) ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= BPC_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            arready_r <= rd_go;
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rresp_r  <= mapped(s_axi_araddr) ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
                rdata_r  <= 32'h0000_0000;
                if (hit(s_axi_araddr, BPC_OFF_PIN)) begin
                    rdata_r[7:0] <= sync2_r;
                end else if (hit(s_axi_araddr, BPC_OFF_DIR)) begin
                    rdata_r[7:0] <= dir_r;
                end else if (hit(s_axi_araddr, BPC_OFF_OPTION)) begin
                    rdata_r[7:0] <= option_r;
                end else if (hit(s_axi_araddr, BPC_OFF_STATUS)) begin
                    rdata_r[BPC_CHG_FLAG_BIT] <= chg_flag_r;
                end else if (hit(s_axi_araddr, BPC_OFF_MASK)) begin
                    rdata_r[BPC_CHG_FLAG_BIT] <= chg_mask_r;
                end else if (hit(s_axi_araddr, BPC_OFF_BITSET) || hit(s_axi_araddr, BPC_OFF_BITCLR)) begin
                    rdata_r[7:0] <= latch_r;
                end
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign pin_out       = pin_out_r;
    assign pin_oe        = pin_oe_r;
    assign pullup_en     = pullup_r;
    assign tap           = tap_r;
    assign irq           = irq_r;
    assign wake_req      = wake_r;

endmodule : bpc_port

/* test/bpc_port_monitor.sv */
/* Concurrent checks on the ports of bpc_port.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ns
module bpc_port_monitor
    import bpc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pullup_en,
    input wire bpc_alt_s    alt,
    input wire logic        lv_prog_enable,
    input wire logic        sleep_active,
    input wire logic        wake_req,
    input wire logic        irq
);
    bpc_alt_s alt_q;
    always_ff @(posedge aclk) begin
        alt_q <= alt;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence wr_answer;
        s_axi_awready && s_axi_wready && s_axi_bvalid;
    endsequence
    a_write_answer: assert property (wr_take |=> wr_answer)
        else $error("write not answered next cycle");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=>
            s_axi_arready && s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    a_pullup_output: assert property ((pullup_en & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_lvp_pullup: assert property (lv_prog_enable |=> !pullup_en[BPC_LVP_PIN])
        else $error("pull-up on programming pin");
    a_pullup_reset: assert property ($rose(aresetn) |-> pullup_en == 8'h00)
        else $error("pull-ups on after reset");
    a_alt_owns: assert property ($past(aresetn) |-> (pin_oe & alt_q.take) == (alt_q.take & alt_q.drive))
        else $error("alternate function not driving its pin");
    a_wake_gated: assert property (wake_req |-> irq && $past(sleep_active))
        else $error("wake without pending interrupt in sleep");
endmodule : bpc_port_monitor

bind bpc_port bpc_port_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .pin_oe(pin_oe), .pullup_en(pullup_en), .alt(alt),
    .lv_prog_enable(lv_prog_enable), .sleep_active(sleep_active), .wake_req(wake_req), .irq(irq));

/* test/bpc_pads.sv */
/* Pad and keypad model on the pin side of bpc_port.
   Assumes the bench sets key levels; undriven pins wander. */
`timescale 1ns/1ns
module bpc_pads (
    input  wire logic       aclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] key_val,
    input  wire logic [7:0] key_en,
    output logic [7:0]      pin_in
);
    logic [7:0] float_r = 8'h00;
    always_ff @(posedge aclk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (key_en[i]) pin_in[i] = key_val[i];
            else if (pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_r[i];
        end
    end
endmodule : bpc_pads

/* test/bpc_port_bench.sv */
/* Self-checking bench for bpc_port with a pad model.
   Assumes a 100 MHz clock and an AXI4-Lite slave that answers in its own time. */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module bpc_port_bench import bpc_pkg::*;;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, pin_in, pin_out, pin_oe, pullup_en, key_val = 0, v, d, e, w, p;
    logic [31:0] wdata = 0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, wake, irq, lvp = 0, sleep = 0;
    logic [1:0]  bresp, rresp, eb;
    logic [33:0] er;
    bpc_alt_s    alt = '0;
    bpc_tap_s    tap;
    logic [7:0]  ken = 8'hFF;
    logic [3:0]  strb = 4'hF;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          failures = 0, tests_run = 0, n;

    initial forever #5 aclk = ~aclk;

    bpc_port i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .alt(alt), .tap(tap), .lv_prog_enable(lvp), .sleep_active(sleep), .wake_req(wake), .irq(irq));
    bpc_pads i_pads (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .key_val(key_val), .key_en(ken), .pin_in(pin_in));

    // answers are matched against the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            er = rq.pop_front();
            `CHK({rresp, rdata}, er)
        end
        if (bvalid && bready) begin
            eb = bq.pop_front();
            `CHK(bresp, eb)
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic hang();
        failures++;
        $display("ERROR %0t: bus gave no answer", $time);
        close_out();
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [7:0] dt, input logic [1:0] r = BPC_RESP_OKAY);
        int k;
        bq.push_back(r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h00_0000, dt};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (k == 50) hang();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] dt, input logic [1:0] r = BPC_RESP_OKAY);
        int k;
        rq.push_back({r, 24'h00_0000, dt});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (k == 50) hang();
    endtask : rd

    task automatic idle(input int c);
        repeat (c) @(posedge aclk);
    endtask : idle

    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note

    initial begin
        void'($urandom(32'h8a8f_b90c));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(pullup_en, 8'h00)
        `CHK(pin_oe, 8'h00)
        rd(BPC_OFF_DIR, 8'hFF);
        rd(BPC_OFF_OPTION, 8'hFF);
        rd(BPC_OFF_STATUS, 8'h00);
        rd(8'h1C, 8'h00, BPC_RESP_SLVERR);
        wr(8'h20, 8'hFF, BPC_RESP_SLVERR);
        note("reset");
        v = 8'($urandom);
        d = 8'($urandom);
        e = 8'($urandom);
        key_val <= e;
        wr(BPC_OFF_PIN, v);
        wr(BPC_OFF_DIR, d);
        idle(4);
        `CHK(pin_oe, ~d)
        `CHK(pin_out & ~d, v & ~d)
        rd(BPC_OFF_PIN, (v & ~d) | (e & d));
        for (int k = 0; k < 2; k++) begin
            w = 8'($urandom);
            p = (v & ~d) | (e & d);
            v = k ? (p & ~w) : (p | w);
            wr(k ? BPC_OFF_BITCLR : BPC_OFF_BITSET, w);
            rd(BPC_OFF_BITSET, v);
            idle(4);
        end
        // a port write with no byte lane still stores the sampled pins
        p = (v & ~d) | (e & d);
        strb <= 4'h0;
        wr(BPC_OFF_PIN, 8'h00);
        strb <= 4'hF;
        rd(BPC_OFF_BITSET, p);
        note("latch");
        key_val <= 8'h00;
        wr(BPC_OFF_PIN, 8'h00);
        wr(BPC_OFF_DIR, 8'hF0);
        wr(BPC_OFF_MASK, 8'h01);
        idle(4);
        rd(BPC_OFF_PIN, 8'h00);
        wr(BPC_OFF_STATUS, 8'h01);
        rd(BPC_OFF_STATUS, 8'h00);
        key_val <= 8'h80;
        for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge aclk);
        `CHK(irq, 1'b1)
        if (irq !== 1'b1) close_out();
        wr(BPC_OFF_STATUS, 8'h01);
        rd(BPC_OFF_STATUS, 8'h01);
        rd(BPC_OFF_PIN, 8'h80);
        wr(BPC_OFF_STATUS, 8'h01);
        rd(BPC_OFF_STATUS, 8'h00);
        sleep   <= 1'b1;
        key_val <= 8'hC0;
        for (n = 0; n < 20 && wake !== 1'b1; n++) @(posedge aclk);
        `CHK(wake, 1'b1)
        if (wake !== 1'b1) close_out();
        sleep <= 1'b0;
        rd(BPC_OFF_PIN, 8'hC0);
        wr(BPC_OFF_STATUS, 8'h01);
        wr(BPC_OFF_DIR, 8'h7F);
        lvp <= 1'b1;
        idle(2);
        key_val <= 8'hD8;
        idle(8);
        rd(BPC_OFF_STATUS, 8'h00);
        note("change");
        wr(BPC_OFF_DIR, 8'hF0);
        wr(BPC_OFF_OPTION, 8'h7F);
        idle(2);
        `CHK(pullup_en, 8'hE0)
        lvp <= 1'b0;
        idle(2);
        `CHK(pullup_en, 8'hF0)
        // release the upper keys: only the pull-ups hold those pins high
        ken <= 8'h0F;
        idle(4);
        rd(BPC_OFF_PIN, 8'hF0);
        ken <= 8'hFF;
        rd(BPC_OFF_OPTION, 8'h7F);
        wr(BPC_OFF_OPTION, 8'hFF);
        idle(2);
        `CHK(pullup_en, 8'h00)
        note("pullup");
        alt <= {3{8'h02}};
        idle(2);
        `CHK(pin_oe[1], 1'b1)
        `CHK(pin_out[1], 1'b1)
        idle(4);
        `CHK(tap.sync_serial_data, 1'b1)
        note("alternate");
        close_out();
    end
endmodule : bpc_port_bench
